// ### common/tpmoc_pkg.sv
/*
 * constants and carrier types of the timer pwm mode and output control slice.
 * assumes one clock domain (pclk) and an apb master with 32-bit data.
 */
package tpmoc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TPMOC_MODE_OFS = 8'h00;
    localparam logic [7:0] TPMOC_FUNC_OFS = 8'h04;
    localparam logic [7:0] TPMOC_OE_OFS   = 8'h08;
    localparam logic [7:0] TPMOC_TRIG_OFS = 8'h0c;
    localparam logic [7:0] TPMOC_STAT_OFS = 8'h10;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] TPMOC_MODE_RST   = 8'h80;
    localparam logic [7:0] TPMOC_FUNC_RST   = 8'hc0;
    localparam logic [7:0] TPMOC_OE_RST     = 8'hff;
    localparam logic [7:0] TPMOC_TRIG_RST   = 8'hff;
    localparam logic [7:0] TPMOC_MODE_WMASK = 8'h1f;
    localparam logic [7:0] TPMOC_FUNC_WMASK = 8'h3f;
    localparam logic [7:0] TPMOC_OE_WMASK   = 8'h3f;
    localparam logic [7:0] TPMOC_TRIG_WMASK = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TPMOC_NCH      = 5;
    localparam int TPMOC_CMB_LSB  = 4;
    localparam int TPMOC_EXT_TRIGGER_DISABLE_BIT = 4;
    localparam int TPMOC_BUF_W    = 4;
    localparam int TPMOC_OE_W     = 6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TPMOC_NORMAL = 3'b001,
        TPMOC_COMPL  = 3'b010,
        TPMOC_RSYNC  = 3'b100
    } tpmoc_comb_type;

    typedef struct packed {
        tpmoc_comb_type               comb;
        logic [TPMOC_BUF_W-1:0]       buffer_en;
        logic [TPMOC_OE_W-1:0]        master_en;
        logic [TPMOC_NCH-1:0]         pwm_mode;
        logic [1:0]                   sync_sel;
    } tpmoc_ctl_type;

    typedef struct packed {
        logic [TPMOC_NCH-1:0] cmp_a;
        logic [TPMOC_NCH-1:0] cmp_b;
    } tpmoc_match_type;

endpackage

// ### design/tpmoc_pwm_chan.sv
/*
 * one pwm waveform former: level rises on match a, falls on match b.
 * assumes match strobes are one-cycle pulses on pclk from the counter logic.
 */
module tpmoc_pwm_chan (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic standby,
    input  wire logic enable,
    input  wire logic match_a,
    input  wire logic match_b,
    output logic      level
);
    import tpmoc_pkg::*;

    typedef struct packed {
        logic level;
    } tpmoc_chan_state_type;

    tpmoc_chan_state_type q;
    tpmoc_chan_state_type d;

    // ------------------------------------------------------------
    // waveform
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (enable && match_b) begin
            d.level = 1'b0;
        end else if (enable && match_a) begin
            d.level = 1'b1;
        end
        if (standby || !enable) begin
            d.level = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;

endmodule

// ### design/tpmoc_top.sv
/*
 * mode, buffer-select and master output enable registers of a five-channel
 * timer, with pwm waveform forming per channel and external-trigger cut-off.
 * assumes apb on pclk, compare/capture strobes and sync bits from timer logic
 * on the same clock, and standby as a synchronous level.
 */
// Local design decisions: the address map and the APB interface to the registers.
module tpmoc_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   standby,
    input  wire tpmoc_pkg::tpmoc_match_type match,
    input  wire logic                   ch1_capture_a,
    input  wire logic                   sync_select_ch3,
    input  wire logic                   sync_select_ch4,
    output tpmoc_pkg::tpmoc_ctl_type    ctl,
    output logic [tpmoc_pkg::TPMOC_NCH-1:0] pwm_level
);
    import tpmoc_pkg::*;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  func;
        logic [7:0]  oe;
        logic [7:0]  trig;
        logic [1:0]  sync_sel;
        logic [31:0] rdata;
        logic        slverr;
    } tpmoc_state_type;

    tpmoc_state_type      q;
    tpmoc_state_type      d;
    tpmoc_comb_type       comb;
    logic                 pair_mode;
    logic                 wr_en;
    logic                 trig_cut;
    logic [TPMOC_NCH-1:0] pwm_active;
    logic [7:0]           rd_mux;
    logic                 rd_hit;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        case (q.func[TPMOC_CMB_LSB+1 -: 2])
            2'b10:   comb = TPMOC_COMPL;
            2'b11:   comb = TPMOC_RSYNC;
            default: comb = TPMOC_NORMAL;
        endcase
    end

    assign pair_mode = (comb != TPMOC_NORMAL);

    // channels 0..2 follow their select bit; 3 and 4 yield to pair modes
    always_comb begin
        pwm_active = q.mode[TPMOC_NCH-1:0];
        if (pair_mode) begin
            pwm_active[4:3] = 2'b00;
        end
    end

    // ------------------------------------------------------------
    // external trigger cut-off
    // ------------------------------------------------------------
    assign trig_cut = ch1_capture_a && !q.trig[TPMOC_EXT_TRIGGER_DISABLE_BIT] && pair_mode;

    // ------------------------------------------------------------
    // apb read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            TPMOC_MODE_OFS: rd_mux = q.mode;
            TPMOC_FUNC_OFS: rd_mux = q.func;
            TPMOC_OE_OFS:   rd_mux = q.oe;
            TPMOC_TRIG_OFS: rd_mux = q.trig;
            TPMOC_STAT_OFS: rd_mux = {comb, pwm_level};
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign wr_en = psel && penable && pwrite;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (psel && !penable) begin
            d.rdata  = {24'h000000, rd_mux};
            d.slverr = !rd_hit;
        end
        if (wr_en) begin
            case (paddr)
                TPMOC_MODE_OFS: begin
                    d.mode = (pwdata[7:0] & TPMOC_MODE_WMASK) | (TPMOC_MODE_RST & ~TPMOC_MODE_WMASK);
                end
                TPMOC_FUNC_OFS: begin
                    d.func = (pwdata[7:0] & TPMOC_FUNC_WMASK) | (TPMOC_FUNC_RST & ~TPMOC_FUNC_WMASK);
                end
                TPMOC_OE_OFS: begin
                    d.oe = (pwdata[7:0] & TPMOC_OE_WMASK) | (TPMOC_OE_RST & ~TPMOC_OE_WMASK);
                end
                TPMOC_TRIG_OFS: begin
                    d.trig = (pwdata[7:0] & TPMOC_TRIG_WMASK) | (TPMOC_TRIG_RST & ~TPMOC_TRIG_WMASK);
                end
                default: begin
                end
            endcase
        end
        // hardware cut beats a software re-enable in the same cycle
        if (trig_cut) begin
            d.oe = q.oe & ~TPMOC_OE_WMASK;
        end
        d.sync_sel = {sync_select_ch4, sync_select_ch3};
        if (standby) begin
            d.mode = TPMOC_MODE_RST;
            d.func = TPMOC_FUNC_RST;
            d.oe   = TPMOC_OE_RST;
            d.trig = TPMOC_TRIG_RST;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.mode     <= TPMOC_MODE_RST;
            q.func     <= TPMOC_FUNC_RST;
            q.oe       <= TPMOC_OE_RST;
            q.trig     <= TPMOC_TRIG_RST;
            q.sync_sel <= 2'b00;
            q.rdata    <= 32'h00000000;
            q.slverr   <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // pwm formers
    // ------------------------------------------------------------
    for (genvar i = 0; i < TPMOC_NCH; i++) begin : g_chan
        tpmoc_pwm_chan u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .standby (standby),
            .enable  (pwm_active[i]),
            .match_a (match.cmp_a[i]),
            .match_b (match.cmp_b[i]),
            .level   (pwm_level[i])
        );
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata  = q.rdata;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && q.slverr;

    always_comb begin
        ctl.comb      = comb;
        ctl.buffer_en = q.func[TPMOC_BUF_W-1:0];
        ctl.master_en = q.oe[TPMOC_OE_W-1:0];
        ctl.pwm_mode  = pwm_active;
        ctl.sync_sel  = q.sync_sel;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_mode_write;
        (wr_en && paddr == TPMOC_MODE_OFS && !standby)
            |=> (q.mode[2:0] == $past(pwdata[2:0])) && q.mode[7];
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bits not stored");

    property p_pwm_high;
        (pwm_active[0] && match.cmp_a[0] && !match.cmp_b[0] && !standby) |=> pwm_level[0];
    endproperty
    a_pwm_high: assert property (p_pwm_high) else $error("pwm did not rise on match a");

    property p_pwm_low;
        (pwm_active[1] && match.cmp_b[1]) |=> !pwm_level[1];
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("pwm did not fall on match b");

    property p_standby_init;
        standby |=> (q.func == TPMOC_FUNC_RST) && (q.oe == TPMOC_OE_RST) && q.trig[TPMOC_EXT_TRIGGER_DISABLE_BIT];
    endproperty
    a_standby_init: assert property (p_standby_init) else $error("standby did not initialise");

    property p_reserved;
        (q.func[7:6] == 2'b11) && (q.oe[7:6] == 2'b11) && q.mode[7];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit not one");

    property p_pair_override;
        (q.func[5] && !standby) |-> (ctl.pwm_mode[4:3] == 2'b00) ##1 !pwm_level[3] && !pwm_level[4];
    endproperty
    a_pair_override: assert property (p_pair_override) else $error("pwm 3/4 active in pair mode");

    property p_sync_kept;
        (sync_select_ch3 && q.func[5]) |=> ctl.sync_sel[0];
    endproperty
    a_sync_kept: assert property (p_sync_kept) else $error("sync lost in pair mode");

    property p_trig_clear;
        (ch1_capture_a && !q.trig[TPMOC_EXT_TRIGGER_DISABLE_BIT] && q.func[5] && !standby) |=> (ctl.master_en == 6'h00);
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear enables");

    property p_trig_ignored;
        (ch1_capture_a && (!q.func[5] || q.trig[TPMOC_EXT_TRIGGER_DISABLE_BIT]) && !wr_en && !standby)
            |=> $stable(q.oe);
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("enables cleared outside trigger");

    property p_buffer_write;
        (wr_en && paddr == TPMOC_FUNC_OFS && !standby && !trig_cut)
            |=> (ctl.buffer_en == $past(pwdata[3:0]));
    endproperty
    a_buffer_write: assert property (p_buffer_write) else $error("buffer select not stored");

    c_compl: cover property (wr_en && paddr == TPMOC_FUNC_OFS && pwdata[5:4] == 2'b10);
    c_cut:   cover property (trig_cut);
    c_pwm:   cover property (pwm_active[2] && match.cmp_a[2] ##[1:20] match.cmp_b[2]);

endmodule

// ### tb/tpmoc_tb.sv
/*
 * self-checking bench of the pwm mode and output control slice.
 * assumes tpmoc_pkg compiled first and tpmoc_top as the device under test.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tpmoc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic            standby, ch1_capture_a, sync_select_ch3, sync_select_ch4;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            err;
    tpmoc_match_type match;
    tpmoc_ctl_type   ctl;
    logic [4:0]      pwm_level;
    int              mismatches, check_count;

    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} tpmoc_row_type;
    localparam tpmoc_row_type ROWS [8] = '{
        '{TPMOC_MODE_OFS, 8'h00, 8'h80}, '{TPMOC_MODE_OFS, 8'hff, 8'h9f},
        '{TPMOC_FUNC_OFS, 8'h00, 8'hc0}, '{TPMOC_FUNC_OFS, 8'hff, 8'hff},
        '{TPMOC_OE_OFS,   8'h00, 8'hc0}, '{TPMOC_OE_OFS,   8'h2a, 8'hea},
        '{TPMOC_TRIG_OFS, 8'h00, 8'hef}, '{TPMOC_TRIG_OFS, 8'hff, 8'hff}};

    tpmoc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .standby(standby), .match(match), .ch1_capture_a(ch1_capture_a), .sync_select_ch3(sync_select_ch3),
        .sync_select_ch4(sync_select_ch4), .ctl(ctl), .pwm_level(pwm_level));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [4:0] a, input logic [4:0] b, input logic cap);
        @(posedge pclk);
        match <= '{cmp_a: a, cmp_b: b};
        ch1_capture_a <= cap;
        @(posedge pclk);
        match <= '0;
        ch1_capture_a <= 1'b0;
        @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        standby = 1'b0;
        match = '0;
        ch1_capture_a = 1'b0;
        sync_select_ch3 = 1'b0;
        sync_select_ch4 = 1'b0;
        mismatches = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then second reset in mid-run
        for (int k = 0; k < 2; k++) begin
            foreach (ROWS[i]) begin
                apb(1'b0, ROWS[i].addr, 8'h00);
                check(rd, {24'h0, i < 2 ? 8'h80 : (i < 4 ? 8'hc0 : 8'hff)});
            end
            foreach (ROWS[i]) begin
                apb(1'b1, ROWS[i].addr, ROWS[i].wdata);
                apb(1'b0, ROWS[i].addr, 8'h00);
                check(rd, {24'h0, ROWS[i].exp});
            end
            @(posedge pclk);
            presetn <= 1'b0;
            @(posedge pclk);
            presetn <= 1'b1;
        end
        // unmapped address refused
        apb(1'b0, 8'h14, 8'h00);
        check({rd[30:0], err}, 32'h1);
        // combination field, buffering and pwm override
        apb(1'b1, TPMOC_MODE_OFS, 8'h1f);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, TPMOC_FUNC_OFS, {2'b00, 2'(i), i[0] ? 4'h6 : 4'h9});
            @(negedge pclk);
            check(32'(ctl.comb), i < 2 ? 32'(TPMOC_NORMAL) : (i == 2 ? 32'(TPMOC_COMPL) : 32'(TPMOC_RSYNC)));
            check(32'(ctl.buffer_en), i[0] ? 32'h6 : 32'h9);
            check(32'(ctl.pwm_mode), i < 2 ? 32'h1f : 32'h07);
        end
        // sync bits stay in force in a pair mode
        apb(1'b1, TPMOC_FUNC_OFS, 8'h20);
        sync_select_ch3 <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(32'(ctl.sync_sel), 32'h1);
        @(posedge pclk);
        sync_select_ch3 <= 1'b0;
        // master enable bits reach the control outputs
        apb(1'b1, TPMOC_OE_OFS, 8'h17);
        @(negedge pclk);
        check(32'(ctl.master_en), 32'h17);
        // external trigger: active, disabled, normal mode
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, TPMOC_FUNC_OFS, k == 2 ? 8'h00 : 8'h20);
            apb(1'b1, TPMOC_TRIG_OFS, k == 1 ? 8'hff : 8'h00);
            apb(1'b1, TPMOC_OE_OFS, 8'h3f);
            pulse(5'h00, 5'h00, 1'b1);
            check(32'(ctl.master_en), k == 0 ? 32'h0 : 32'h3f);
        end
        // pwm waveform per channel
        apb(1'b1, TPMOC_MODE_OFS, 8'h07);
        for (int c = 0; c < 3; c++) begin
            pulse(5'(1 << c), 5'h00, 1'b0);
            check(32'(pwm_level), 32'(1 << c));
            pulse(5'h00, 5'(1 << c), 1'b0);
            check(32'(pwm_level), 32'h0);
        end
        pulse(5'h01, 5'h00, 1'b0);
        pulse(5'h01, 5'h01, 1'b0);
        check(32'(pwm_level), 32'h0);
        apb(1'b1, TPMOC_MODE_OFS, 8'h18);
        pulse(5'h18, 5'h00, 1'b0);
        check(32'(pwm_level), 32'h18);
        apb(1'b1, TPMOC_FUNC_OFS, 8'h30);
        pulse(5'h18, 5'h00, 1'b0);
        check(32'(pwm_level), 32'h00);
        apb(1'b0, TPMOC_STAT_OFS, 8'h00);
        check(rd, {24'h0, TPMOC_RSYNC, 5'h00});
        apb(1'b1, TPMOC_FUNC_OFS, 8'h00);
        apb(1'b1, TPMOC_MODE_OFS, 8'h00);
        pulse(5'h01, 5'h00, 1'b0);
        check(32'(pwm_level), 32'h0);
        // standby restores reset values
        apb(1'b1, TPMOC_MODE_OFS, 8'h07);
        apb(1'b1, TPMOC_FUNC_OFS, 8'h3f);
        apb(1'b1, TPMOC_OE_OFS, 8'h00);
        pulse(5'h01, 5'h00, 1'b0);
        @(posedge pclk);
        standby <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(32'({ctl.buffer_en, ctl.master_en, pwm_level}), 32'({4'h0, 6'h3f, 5'h00}));
        @(posedge pclk);
        standby <= 1'b0;
        apb(1'b0, TPMOC_FUNC_OFS, 8'h00);
        check(rd, 32'hc0);
        apb(1'b0, TPMOC_OE_OFS, 8'h00);
        check(rd, 32'hff);
        apb(1'b0, TPMOC_MODE_OFS, 8'h00);
        check(rd, 32'h80);
        apb(1'b0, TPMOC_TRIG_OFS, 8'h00);
        check(rd, 32'hff);
        report_and_stop();
    end
endmodule
